// File: src/modsel_counter_dev.sv
`timescale 1ns/1ps
`default_nettype none
module modsel_counter_dev
	import modsel_counter_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	modsel_counter_if.device link,
	output logic [3:0] count_value,
	output logic carry_msb
);
	logic gate_prev_reg;
	logic [3:0] count_reg;
	logic [3:0] count_next;
	wire gate_fall = gate_prev_reg & ~link.count_gate;
	wire dec_wrap = link.binary_strap_n & (count_reg == DEC_LAST);
	wire [3:0] count_inc = count_reg + 4'h1;

	always_comb begin
		count_next = count_reg;
		if (!link.async_clear_n) begin
			count_next = COUNT_RESET;
		end else if (gate_fall) begin
			if (link.sync_reset) begin
				count_next = COUNT_RESET;
			end else if (dec_wrap) begin
				count_next = COUNT_RESET;
			end else begin
				count_next = count_inc;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_prev_reg <= 1'b1;
			count_reg <= COUNT_RESET;
		end else begin
			gate_prev_reg <= link.count_gate;
			count_reg <= count_next;
		end
	end

	// weights 1,2,4,8 on bits 0..3
	assign link.count_q = count_reg;
	assign count_value = count_reg;
	// msb falls on wrap except with a modulus of 2 to 8, so it clocks the next stage directly
	assign carry_msb = count_reg[3];
endmodule // modsel_counter_dev
`default_nettype wire

// File: src/modsel_counter_host.sv
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module modsel_counter_host
	import modsel_counter_pkg::*;
#(
	parameter int SLOW_GAP_CYCLES = SLOW_CYCLES
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	modsel_counter_if.host link
);
	localparam logic [TIMER_W-1:0] SETTLE_T = TIMER_W'(SETTLE_CYCLES);
	localparam logic [TIMER_W-1:0] CLEAR_T = TIMER_W'(CLEAR_CYCLES);
	localparam logic [TIMER_W-1:0] LOW_T = TIMER_W'(GATE_LOW_CYCLES);
	localparam logic [TIMER_W-1:0] SLOW_T = TIMER_W'(SLOW_GAP_CYCLES);

	host_state_t state_reg;
	host_state_t state_next;
	logic [31:0] ctrl_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic count_pend_reg;
	logic clear_pend_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic [TIMER_W-1:0] timer_next;
	logic [TIMER_W-1:0] quiet_reg;
	logic [TIMER_W-1:0] quiet_next;
	logic gate_reg;
	logic gate_next;
	logic clear_n_reg;
	logic binary_n_reg;
	logic slow_n_reg;
	logic [4:0] mod_reg;
	logic sync_reg;

	// apb decode
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire hit_ctrl = (paddr == CTRL_OFF);
	wire hit_cmd = (paddr == CMD_OFF);
	wire hit_status = (paddr == STATUS_OFF);
	wire hit_any = hit_ctrl | hit_cmd | hit_status;
	wire wr_ctrl = access & pwrite & hit_ctrl;
	wire wr_cmd = access & pwrite & hit_cmd;
	wire cmd_count = wr_cmd & pwdata[CMD_COUNT_BIT];
	wire cmd_clear = wr_cmd & pwdata[CMD_CLEAR_BIT];

	wire busy = (state_reg != ST_IDLE);
	wire [31:0] status_word = {25'h000_0000, sync_reg, count_pend_reg,
		busy, link.count_q};
	wire [31:0] read_mux = hit_ctrl ? ctrl_reg :
		hit_status ? status_word : 32'h0000_0000;

	// straps and modulus, taken from ctrl only while clearing
	wire [4:0] ctrl_mod = ctrl_reg[CTRL_MOD_LSB +: 5];
	wire mod_valid = (ctrl_mod >= MOD_MIN) & (ctrl_mod <= MOD_MAX);
	wire force_bin = mod_valid & (ctrl_mod > MOD_DEC_MAX);
	wire bin_want = ctrl_reg[CTRL_BINARY_BIT] | force_bin;

	// decode modulus minus one by sensing only its one bits, so 12,
	// 14 and 15 need three outputs and lower states never alias
	wire [4:0] mod_m1 = mod_reg - 5'h01;
	wire [3:0] sense_mask = mod_m1[3:0];
	wire dec_en = (mod_reg >= MOD_MIN) & (mod_reg <= MOD_MAX);
	wire dec_hit = dec_en &
		((link.count_q & sense_mask) == sense_mask);
	wire sync_chg = dec_hit ^ sync_reg;

	wire [TIMER_W-1:0] gap = slow_n_reg ? SETTLE_T : SLOW_T;
	wire gap_ok = (quiet_reg >= gap) & ~sync_chg;
	wire quiet_sat = &quiet_reg;
	wire [TIMER_W-1:0] quiet_inc = quiet_reg + TIMER_W'(1);
	wire [TIMER_W-1:0] timer_inc = timer_reg + TIMER_W'(1);

	always_comb begin
		state_next = state_reg;
		timer_next = timer_inc;
		quiet_next = quiet_sat ? quiet_reg : quiet_inc;
		gate_next = gate_reg;
		if (sync_chg) begin
			quiet_next = '0;
		end
		unique case (state_reg)
			ST_CLEAR: begin
				if (timer_reg >= CLEAR_T) begin
					state_next = ST_IDLE;
					quiet_next = '0;
				end
			end
			ST_IDLE: begin
				timer_next = '0;
				if (clear_pend_reg) begin
					state_next = ST_CLEAR;
				end else if (count_pend_reg && gap_ok) begin
					gate_next = 1'b0;
					state_next = ST_LOW;
				end
			end
			ST_LOW: begin
				if (timer_reg >= LOW_T) begin
					gate_next = 1'b1;
					quiet_next = '0;
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	wire count_taken = (state_reg == ST_IDLE) & ~clear_pend_reg &
		count_pend_reg & gap_ok;
	wire clear_taken = (state_reg == ST_IDLE) & clear_pend_reg;
	wire in_clear = (state_next == ST_CLEAR);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RESET;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= pwdata;
			end
			if (setup) begin
				prdata_reg <= pwrite ? 32'h0000_0000 : read_mux;
				pslverr_reg <= ~hit_any;
			end
		end
	end

	// a new command wins over the clear of its pending flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_pend_reg <= 1'b0;
			clear_pend_reg <= 1'b0;
		end else begin
			count_pend_reg <= cmd_count | (count_pend_reg & ~count_taken);
			clear_pend_reg <= cmd_clear | (clear_pend_reg & ~clear_taken);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_CLEAR;
			timer_reg <= '0;
			quiet_reg <= '0;
			gate_reg <= 1'b1;
			sync_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			quiet_reg <= quiet_next;
			gate_reg <= gate_next;
			sync_reg <= dec_hit;
		end
	end

	// straps only move while the counter is held clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_n_reg <= 1'b0;
			binary_n_reg <= 1'b1;
			slow_n_reg <= 1'b1;
			mod_reg <= 5'h00;
		end else begin
			clear_n_reg <= ~in_clear;
			if (in_clear) begin
				binary_n_reg <= ~bin_want;
				slow_n_reg <= ~ctrl_reg[CTRL_SLOW_BIT];
				mod_reg <= mod_valid ? ctrl_mod : 5'h00;
			end
		end
	end

	assign link.count_gate = gate_reg;
	assign link.async_clear_n = clear_n_reg;
	assign link.sync_reset = sync_reg;
	assign link.binary_strap_n = binary_n_reg;
	assign link.slow_strap_n = slow_n_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg & access;
	assign pready = 1'b1;
endmodule // modsel_counter_host
`default_nettype wire

// File: src/modsel_counter_if.sv
`timescale 1ns/1ps
`default_nettype none
interface modsel_counter_if;
	logic count_gate;
	logic async_clear_n;
	logic sync_reset;
	logic binary_strap_n;
	logic slow_strap_n;
	logic [3:0] count_q;

	modport device (
		input count_gate,
		input async_clear_n,
		input sync_reset,
		input binary_strap_n,
		input slow_strap_n,
		output count_q
	);
	modport host (
		output count_gate,
		output async_clear_n,
		output sync_reset,
		output binary_strap_n,
		output slow_strap_n,
		input count_q
	);
endinterface
`default_nettype wire

// File: src/modsel_counter_pkg.sv
`default_nettype none
package modsel_counter_pkg;
	// clock and timing
	localparam int CLK_MHZ = 250;
	localparam int T_SETTLE_NS = 4000;
	localparam int T_SLOW_NS = 50000;
	localparam int T_CLEAR_NS = 4000;
	localparam int T_GATE_LOW_NS = 4000;
	localparam int SETTLE_CYCLES = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int SLOW_CYCLES = (T_SLOW_NS * CLK_MHZ + 999) / 1000;
	localparam int CLEAR_CYCLES = (T_CLEAR_NS * CLK_MHZ + 999) / 1000;
	localparam int GATE_LOW_CYCLES = (T_GATE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int TIMER_W = 16;

	// counter layout
	localparam int STAGES = 4;
	localparam logic [3:0] DEC_LAST = 4'h9;
	localparam logic [3:0] COUNT_RESET = 4'h0;
	localparam logic [4:0] MOD_MIN = 5'h02;
	localparam logic [4:0] MOD_MAX = 5'h10;
	localparam logic [4:0] MOD_DEC_MAX = 5'h0a;

	// register map
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] CMD_OFF = 12'h004;
	localparam logic [11:0] STATUS_OFF = 12'h008;
	localparam int CTRL_BINARY_BIT = 0;
	localparam int CTRL_SLOW_BIT = 1;
	localparam int CTRL_MOD_LSB = 4;
	localparam int CMD_COUNT_BIT = 0;
	localparam int CMD_CLEAR_BIT = 1;
	localparam int STAT_BUSY_BIT = 4;
	localparam int STAT_PEND_BIT = 5;
	localparam int STAT_SYNC_BIT = 6;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_CLEAR,
		ST_IDLE,
		ST_LOW
	} host_state_t;
endpackage
`default_nettype wire

// File: tb/modsel_counter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module modsel_counter_asserts
	import modsel_counter_pkg::*;
#(
	parameter int SLOW_GAP_CYCLES = SLOW_CYCLES
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic count_gate,
	input wire logic async_clear_n,
	input wire logic sync_reset,
	input wire logic binary_strap_n,
	input wire logic slow_strap_n,
	input wire logic [3:0] count_q
);
	logic [15:0] quiet_reg;
	logic [15:0] low_reg;
	logic gate_q;
	logic sync_q;
	logic clear_q;
	// edge history kept by hand, so no clock has to be inferred here
	wire restart = (count_gate & ~gate_q) | (sync_reset ^ sync_q) |
		(async_clear_n & ~clear_q);
	wire quiet_full = &quiet_reg;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// edges since the last event that restarts the settling wait;
	// saturates so a long idle stretch never wraps into a false alarm
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_reg <= '0;
			low_reg <= '0;
			gate_q <= 1'b1;
			sync_q <= 1'b0;
			clear_q <= 1'b0;
		end else begin
			gate_q <= count_gate;
			sync_q <= sync_reset;
			clear_q <= async_clear_n;
			if (restart) begin
				quiet_reg <= '0;
			end else if (!quiet_full) begin
				quiet_reg <= quiet_reg + 16'h0001;
			end
			low_reg <= async_clear_n ? 16'h0000 : low_reg + 16'h0001;
		end
	end
	sequence fall_s;
		$fell(count_gate) && async_clear_n;
	endsequence
	sequence plain_fall_s;
		fall_s ##0 (!sync_reset && !(binary_strap_n && count_q == 4'h9));
	endsequence
	count_step_a: assert property (
		plain_fall_s |=> count_q == $past(count_q) + 4'h1)
		else $error("count did not advance by one");
	dec_wrap_a: assert property (
		fall_s ##0 (binary_strap_n && count_q == 4'h9) |=> count_q == 4'h0)
		else $error("decimal count did not wrap");
	sync_zero_a: assert property (
		fall_s ##0 sync_reset |=> count_q == 4'h0)
		else $error("sync reset did not zero the count");
	clear_zero_a: assert property (
		!async_clear_n |=> count_q == 4'h0)
		else $error("clear did not hold zero");
	no_count_a: assert property (
		async_clear_n && !$fell(count_gate) |=> $stable(count_q))
		else $error("count moved without a falling gate");
	gap_a: assert property (
		$fell(count_gate) |-> quiet_reg >=
		(slow_strap_n ? SETTLE_CYCLES : SLOW_GAP_CYCLES) - 1)
		else $error("gate fell too soon");
	clear_len_a: assert property (
		$rose(async_clear_n) |-> low_reg >= CLEAR_CYCLES - 1)
		else $error("clear released too early");
	strap_hold_a: assert property (
		async_clear_n && $past(async_clear_n) |->
		$stable(binary_strap_n) && $stable(slow_strap_n))
		else $error("strap changed while counting");
endmodule // modsel_counter_asserts
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import modsel_counter_pkg::*;
;
	// short slow gap keeps the run small
	localparam int GAP = 50;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] count_value;
	logic carry_msb;
	logic [3:0] last_q = 4'h0;
	logic [3:0] cur = 4'h0;
	logic [3:0] wrap = 4'h9;
	logic [31:0] rd_data = 32'h0000_0000;
	logic [32:0] exp_q;
	logic [32:0] rq[$];
	logic [32:0] cq[$];
	int bad_count = 0;
	int n_tests = 0;
	modsel_counter_if link();
	modsel_counter_host #(.SLOW_GAP_CYCLES(GAP)) modsel_counter_host_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));
	modsel_counter_dev modsel_counter_dev_i (.pclk(pclk), .presetn(presetn),
		.link(link), .count_value(count_value), .carry_msb(carry_msb));
	modsel_counter_asserts #(.SLOW_GAP_CYCLES(GAP)) modsel_counter_asserts_i (
		.pclk(pclk), .presetn(presetn), .count_gate(link.count_gate),
		.async_clear_n(link.async_clear_n), .sync_reset(link.sync_reset),
		.binary_strap_n(link.binary_strap_n),
		.slow_strap_n(link.slow_strap_n), .count_q(link.count_q));
	task automatic conclude();
		if (bad_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_count(input logic [3:0] q, input logic c,
			input logic [32:0] exp);
		cmp({28'h000_0000, c, q}, exp);
	endtask
	// ends one idle edge after release so back-to-back calls never clash
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge pclk);
			// read data is taken at the edge that sees pready
			if (pready === 1'b1) begin
				rd_data = prdata;
				break;
			end
		end
		if (i == 100) begin
			bad_count++;
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic settle();
		for (int i = 0; i < 4000; i++) begin
			apb(1'b0, STATUS_OFF, 32'h0000_0000);
			if (rd_data[STAT_BUSY_BIT] === 1'b0 &&
					rd_data[STAT_PEND_BIT] === 1'b0)
				return;
		end
		bad_count++;
		conclude();
	endtask
	task automatic count();
		cur = (cur == wrap) ? 4'h0 : cur + 4'h1;
		cq.push_back({28'h000_0000, cur[3], cur});
		apb(1'b1, CMD_OFF, 32'h0000_0001);
		settle();
	endtask
	task automatic setup(input logic bin, input logic [4:0] m);
		apb(1'b1, CTRL_OFF, {23'h00_0000, m, 3'h1, bin});
		wrap = (m >= MOD_MIN && m <= MOD_MAX) ? 4'(m - 5'h01) : 4'hf;
		cq.push_back(33'h0_0000_0000);
		apb(1'b1, CMD_OFF, 32'h0000_0002);
		settle();
		cur = 4'h0;
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && rq.size() > 0)
			cmp({pslverr, prdata}, rq.pop_front());
		last_q <= count_value;
		if (count_value !== last_q) begin
			exp_q = (cq.size() > 0) ? cq.pop_front() : '1;
			cmp_count(count_value, carry_msb, exp_q);
		end
	end
	initial begin
		forever #2 pclk = ~pclk;
	end
	initial begin
		int m;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(4));
		rd(CTRL_OFF, {1'b0, CTRL_RESET});
		rd(12'h00c, 33'h1_0000_0000);
		settle();
		repeat (11) count();
		rd(STATUS_OFF, {29'h0000_0000, cur});
		setup(1'b1, 5'h10);
		rd(CTRL_OFF, 33'h0_0000_0103);
		repeat (17) count();
		setup(1'b0, 5'h0c);
		repeat (13) count();
		m = $urandom_range(16, 2);
		setup(m[0], m[4:0]);
		repeat (m + 1) count();
		// a note left over is a result the design never produced
		if (cq.size() != 0 || rq.size() != 0)
			bad_count++;
		conclude();
	end
endmodule // tb_top
`default_nettype wire
